// File: include/txdma_pkg.sv
// Constants and types for the transmit command fetch engine.
// Assumes one 32-bit host memory port and a 250 MHz core clock.
`default_nettype none
package txdma_pkg;
    localparam int          DW           = 32;
    localparam logic [31:0] OFS_GP       = 32'h4;
    localparam logic [31:0] OFS_DATA_STD = 32'h10;
    localparam logic [31:0] OFS_DATA_EXT = 32'h20;
    localparam logic [31:0] NULL_PTR     = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_STEP    = 32'h4;
    localparam int          TBD_SHIFT    = 3;
    localparam logic [7:0]  EMB_TBDS     = 8'h2;
    localparam logic [2:0]  W_CMD        = 3'h0;
    localparam logic [2:0]  W_ARR        = 3'h2;
    localparam logic [2:0]  W_CNT        = 3'h3;
    localparam logic [2:0]  W_STD_LAST   = 3'h3;
    localparam logic [2:0]  W_EXT_LAST   = 3'h7;
    localparam logic [2:0]  OP_TX        = 3'h4;
    localparam int          OP_LO        = 16;
    localparam int          THR_LO       = 16;
    localparam int          NUM_LO       = 24;
    localparam int          C_BIT        = 15;
    localparam int          OK_BIT       = 13;
    localparam int          U_BIT        = 12;
    localparam int          EL_BIT       = 16;
    localparam int          THR_SHIFT    = 3;
    localparam logic [13:0] WORD_BYTES   = 14'h4;
    localparam logic [4:0]  RETRY_LIM    = 5'hF;
    localparam int          CLK_NS       = 4;
    localparam int          POLL_NS      = 1000;
    localparam int          POLL_CYC     = POLL_NS / CLK_NS;
    typedef enum logic [3:0] {
        S_IDLE, S_SCB_CMD, S_SCB_PTR, S_SCB_CLR, S_TCB, S_IMM,
        S_EOC, S_DESC, S_POLL, S_BUF, S_STAT, S_FIN
    } state_e;
endpackage
`default_nettype wire

// File: logic/tx_descriptor_fetch_dma.sv
// Transmit command engine: fetches command blocks and buffer descriptors,
// streams frame data to the transmit FIFO, posts completion status.
// Assumes a memory port with one outstanding access, ack on completion.
// Functional notes
// - Extended mode reads eight command words instead of four.
// - Extended mode: array address points at the third descriptor.
// - Extended mode: count includes both embedded descriptors.
// - Extended block is flexible; embedded pointers nonzero, set by driver.
// - Descriptor holds absolute 32-bit address and 14-bit byte count.
// - Dynamic mode: zero pointer is discarded and fetched again.
// - Frame ends at the last counted descriptor regardless of end flag.
// - Valid pointer with end flag ends the frame early.
// - Dynamic order: data, descriptors, poll, buffer, status, finish.
// - Collisions retried from FIFO up to 15; sixteenth bumps counter.
// - Opcode 100b in the command word requests transmission.
// - Start reads command, general pointer, then clears command word.
// - Immediate data is fetched before any buffer data.
// - Transmission starts once threshold bytes were fetched.
// - Completion bit written after last buffer, with underrun flag.
// - Next descriptor prefetched before the current buffer is moved.
// - Standard mode, null array with immediate data: end-of-command word after data.
// - Zero immediate count skips the data phase; no word is pushed.
// - Completion posted at FIFO entry; wire status other than underrun only counts.
// - Jam after preamble only; late collision is not jammed.
// - Statistics counters follow status from the wire side.
// - Threshold field times eight gives the byte threshold.
// - Zero descriptor count means null array, frame ends.
`timescale 1ns/10ps
`default_nettype none
module tx_descriptor_fetch_dma
    import txdma_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             cu_start,
    input  wire logic [31:0]      scb_addr,
    input  wire logic             ext_mode,
    input  wire logic             dyn_mode,
    output logic                  mem_req,
    output logic                  mem_we,
    output logic [31:0]           mem_addr,
    output logic [31:0]           mem_wdata,
    input  wire logic             mem_ack,
    input  wire logic [31:0]      mem_rdata,
    output logic                  fifo_valid,
    output logic [31:0]           fifo_data,
    output logic                  fifo_eoc,
    input  wire logic             fifo_ready,
    output logic                  tx_go,
    output logic                  cmd_done,
    input  wire logic             wire_pre_done,
    input  wire logic             wire_coll,
    input  wire logic             wire_late,
    input  wire logic             wire_urun,
    input  wire logic             wire_done,
    output logic                  retx,
    output logic                  jam,
    output logic [CNT_W-1:0]      ok_cnt,
    output logic [CNT_W-1:0]      maxcol_cnt,
    output logic [CNT_W-1:0]      urun_cnt
);
    state_e      state, next_state;
    logic [2:0]  wi, next_wi;
    logic [31:0] tcb_addr, next_tcb_addr, tbd_arr, next_tbd_arr;
    logic [15:0] cmd_hi, next_cmd_hi;
    logic [13:0] bcnt, next_bcnt;
    logic [7:0]  thr, next_thr, tbd_num, next_tbd_num, idx, next_idx;
    logic [31:0] ed_ptr [2], next_ed_ptr [2], ed_w [2], next_ed_w [2];
    logic [31:0] dptr, next_dptr, addr, next_addr;
    logic [31:0] nxt_ptr, next_nxt_ptr;
    logic [13:0] rem, next_rem, nxt_sz, next_nxt_sz;
    logic        have_cur, next_have_cur, cur_last, next_cur_last;
    logic        nxt_last, next_nxt_last, go_done, next_go_done;
    logic [15:0] fetched, next_fetched;
    logic [15:0] poll, next_poll;
    logic        urun_flag, next_urun_flag;
    logic        next_mem_req, next_mem_we, next_tx_go, next_cmd_done;
    logic [31:0] next_mem_addr, next_mem_wdata;
    logic        push, push_eoc, room, acc;
    logic        got, last;
    logic [31:0] gp, gw, daddr;
    logic [7:0]  aidx;
    logic [13:0] take;
    logic [31:0] out_d, next_out_d, sk_d, next_sk_d;
    logic        out_e, next_out_e, sk_e, next_sk_e;
    logic        out_v, next_out_v, sk_v, next_sk_v;

    assign acc  = mem_req & mem_ack;
    assign room = !sk_v;
    assign take = (rem > WORD_BYTES) ? WORD_BYTES : rem;
    assign aidx  = ext_mode ? idx - EMB_TBDS : idx;
    assign daddr = tbd_arr + ({24'h0, aidx} << TBD_SHIFT)
                 + (wi[0] ? WORD_STEP : 32'h0);

    always_comb begin
        next_state = state;         next_wi = wi;
        next_tcb_addr = tcb_addr;   next_tbd_arr = tbd_arr;
        next_cmd_hi = cmd_hi;       next_bcnt = bcnt;
        next_thr = thr;             next_tbd_num = tbd_num;
        next_ed_ptr = ed_ptr;       next_ed_w = ed_w;
        next_idx = idx;             next_dptr = dptr;
        next_addr = addr;           next_rem = rem;
        next_nxt_ptr = nxt_ptr;     next_nxt_sz = nxt_sz;
        next_have_cur = have_cur;   next_cur_last = cur_last;
        next_nxt_last = nxt_last;   next_go_done = go_done;
        next_fetched = fetched;     next_poll = poll;
        next_mem_req = mem_req;     next_mem_we = mem_we;
        next_mem_addr = mem_addr;   next_mem_wdata = mem_wdata;
        next_tx_go = 1'b0;          next_cmd_done = 1'b0;
        next_urun_flag = urun_flag | wire_urun;
        push = 1'b0;                push_eoc = 1'b0;
        got = 1'b0;                 last = 1'b0;
        gp = 32'h0;                 gw = 32'h0;
        if (acc) begin
            next_mem_req = 1'b0;
            next_mem_we = 1'b0;
        end
        unique case (state)
            S_IDLE: if (cu_start) begin
                next_state = S_SCB_CMD;
                next_fetched = 16'h0;
                next_go_done = 1'b0;
            end
            S_SCB_CMD: if (!mem_req) begin
                next_mem_req = 1'b1;
                next_mem_addr = scb_addr;
            end else if (mem_ack) next_state = S_SCB_PTR;
            S_SCB_PTR: if (!mem_req) begin
                next_mem_req = 1'b1;
                next_mem_addr = scb_addr + OFS_GP;
            end else if (mem_ack) begin
                next_tcb_addr = mem_rdata;
                next_state = S_SCB_CLR;
            end
            S_SCB_CLR: if (!mem_req) begin
                next_mem_req = 1'b1;
                next_mem_we = 1'b1;
                next_mem_addr = scb_addr;
                next_mem_wdata = 32'h0;
            end else if (mem_ack) begin
                next_state = S_TCB;
                next_wi = 3'h0;
            end
            S_TCB: if (!mem_req) begin
                next_mem_req = 1'b1;
                next_mem_addr = tcb_addr + {27'h0, wi, 2'h0};
            end else if (mem_ack) begin
                next_wi = wi + 3'h1;
                unique case (wi)
                    W_CMD: next_cmd_hi = mem_rdata[31:16];
                    W_ARR: next_tbd_arr = mem_rdata;
                    W_CNT: begin
                        next_bcnt = mem_rdata[13:0];
                        next_rem = mem_rdata[13:0];
                        next_thr = mem_rdata[THR_LO +: 8];
                        next_tbd_num = mem_rdata[NUM_LO +: 8];
                        next_addr = tcb_addr
                                  + (ext_mode ? OFS_DATA_EXT : OFS_DATA_STD);
                    end
                    3'h4, 3'h6: next_ed_ptr[wi[1]] = mem_rdata;
                    3'h5, 3'h7: next_ed_w[wi[1]] = mem_rdata;
                    default: ;
                endcase
                if (wi == W_CMD && mem_rdata[OP_LO +: 3] != OP_TX)
                    next_state = S_FIN;
                else if (wi == (ext_mode ? W_EXT_LAST : W_STD_LAST))
                    next_state = S_IMM;
            end
            // immediate data first, zero count acts as dummy
            S_IMM, S_BUF: if (rem == 14'h0) begin
                next_idx = 8'h0;
                next_have_cur = 1'b0;
                if (state == S_IMM) begin
                    if (bcnt != 14'h0 && tbd_arr == NULL_PTR && !ext_mode)
                        next_state = S_EOC;
                    else if (tbd_num == 8'h0)
                        next_state = S_STAT;
                    else
                        next_state = S_DESC;
                end else if (cur_last) next_state = S_STAT;
                else begin
                    next_idx = idx;
                    next_have_cur = 1'b1;
                    next_addr = nxt_ptr;
                    next_rem = nxt_sz;
                    next_cur_last = nxt_last;
                    next_state = nxt_last ? S_BUF : S_DESC;
                end
            end else if (!mem_req && room) begin
                next_mem_req = 1'b1;
                next_mem_addr = addr;
            end else if (acc) begin
                push = 1'b1;
                next_addr = addr + WORD_STEP;
                next_rem = rem - take;
                next_fetched = fetched + {2'h0, take};
            end
            S_EOC: if (room) begin
                push = 1'b1;
                push_eoc = 1'b1;
                next_state = S_STAT;
            end
            S_DESC: begin
                // embedded descriptors come from the block
                if (ext_mode && idx < EMB_TBDS) begin
                    got = 1'b1;
                    gp = ed_ptr[idx[0]];
                    gw = ed_w[idx[0]];
                end else if (!mem_req) begin
                    next_mem_req = 1'b1;
                    next_mem_addr = daddr;
                end else if (mem_ack) begin
                    next_wi = {2'h0, !wi[0]};
                    if (!wi[0]) next_dptr = mem_rdata;
                    else begin
                        got = 1'b1;
                        gp = dptr;
                        gw = mem_rdata;
                    end
                end
                if (got && dyn_mode && gp == 32'h0) begin
                    next_state = S_POLL;
                    next_poll = 16'(POLL_CYC);
                end else if (got) begin
                    // last by count or end flag
                    last = gw[EL_BIT] || (idx + 8'h1 == tbd_num);
                    next_idx = idx + 8'h1;
                    if (!have_cur) begin
                        next_have_cur = 1'b1;
                        next_addr = gp;
                        next_rem = gw[13:0];
                        next_cur_last = last;
                        next_state = last ? S_BUF : S_DESC;
                    end else begin
                        next_nxt_ptr = gp;
                        next_nxt_sz = gw[13:0];
                        next_nxt_last = last;
                        next_state = S_BUF;
                    end
                end
            end
            S_POLL: begin
                next_poll = poll - 16'h1;
                if (poll <= 16'h1) next_state = S_DESC;
            end
            // completion once frame is in the FIFO
            S_STAT: if (!mem_req) begin
                next_mem_req = 1'b1;
                next_mem_we = 1'b1;
                next_mem_addr = tcb_addr;
                next_mem_wdata = {cmd_hi, 16'h0};
                next_mem_wdata[C_BIT] = 1'b1;
                next_mem_wdata[OK_BIT] = 1'b1;
                next_mem_wdata[U_BIT] = urun_flag;
            end else if (mem_ack) begin
                next_urun_flag = wire_urun;
                next_state = S_FIN;
            end
            S_FIN: begin
                next_cmd_done = 1'b1;
                next_state = S_IDLE;
            end
        endcase
        // threshold times eight
        // Stale threshold from the last block is ignored until reloaded
        if (!go_done && (state inside {S_IMM, S_EOC, S_DESC, S_POLL, S_BUF})
            && fetched >= {5'h0, thr, 3'h0} || !go_done && state == S_STAT)
        begin
            next_tx_go = 1'b1;
            next_go_done = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;      wi <= 3'h0;
            tcb_addr <= 32'h0;    tbd_arr <= 32'h0;
            cmd_hi <= 16'h0;      bcnt <= 14'h0;
            thr <= 8'h0;          tbd_num <= 8'h0;
            ed_ptr <= '{default: 32'h0};
            ed_w <= '{default: 32'h0};
            idx <= 8'h0;          dptr <= 32'h0;
            addr <= 32'h0;        rem <= 14'h0;
            nxt_ptr <= 32'h0;     nxt_sz <= 14'h0;
            have_cur <= 1'b0;     cur_last <= 1'b0;
            nxt_last <= 1'b0;     go_done <= 1'b0;
            fetched <= 16'h0;     poll <= 16'h0;
            urun_flag <= 1'b0;    mem_req <= 1'b0;
            mem_we <= 1'b0;       mem_addr <= 32'h0;
            mem_wdata <= 32'h0;   tx_go <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            state <= next_state;  wi <= next_wi;
            tcb_addr <= next_tcb_addr;
            tbd_arr <= next_tbd_arr;
            cmd_hi <= next_cmd_hi; bcnt <= next_bcnt;
            thr <= next_thr;      tbd_num <= next_tbd_num;
            ed_ptr <= next_ed_ptr; ed_w <= next_ed_w;
            idx <= next_idx;      dptr <= next_dptr;
            addr <= next_addr;    rem <= next_rem;
            nxt_ptr <= next_nxt_ptr; nxt_sz <= next_nxt_sz;
            have_cur <= next_have_cur; cur_last <= next_cur_last;
            nxt_last <= next_nxt_last; go_done <= next_go_done;
            fetched <= next_fetched; poll <= next_poll;
            urun_flag <= next_urun_flag; mem_req <= next_mem_req;
            mem_we <= next_mem_we; mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata; tx_go <= next_tx_go;
            cmd_done <= next_cmd_done;
        end
    end

    // Two-entry skid buffer; reads are issued only with a free slot
    always_comb begin
        next_out_v = out_v; next_out_d = out_d; next_out_e = out_e;
        next_sk_v = sk_v;   next_sk_d = sk_d;   next_sk_e = sk_e;
        if (out_v && fifo_ready) begin
            next_out_v = sk_v;
            next_out_d = sk_d;
            next_out_e = sk_e;
            next_sk_v = 1'b0;
        end
        if (push && !next_out_v) begin
            next_out_v = 1'b1;
            next_out_d = push_eoc ? 32'h0 : mem_rdata;
            next_out_e = push_eoc;
        end else if (push) begin
            next_sk_v = 1'b1;
            next_sk_d = push_eoc ? 32'h0 : mem_rdata;
            next_sk_e = push_eoc;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_v <= 1'b0; out_d <= 32'h0; out_e <= 1'b0;
            sk_v <= 1'b0;  sk_d <= 32'h0;  sk_e <= 1'b0;
        end else begin
            out_v <= next_out_v; out_d <= next_out_d; out_e <= next_out_e;
            sk_v <= next_sk_v;   sk_d <= next_sk_d;   sk_e <= next_sk_e;
        end
    end
    assign fifo_valid = out_v;
    assign fifo_data  = out_d;
    assign fifo_eoc   = out_e;

    // Wire side: retries come from FIFO data, no new memory traffic
    logic [4:0]       tries, next_tries;
    logic             jam_pend, next_jam_pend, next_retx, next_jam;
    logic [CNT_W-1:0] next_ok_cnt, next_maxcol_cnt, next_urun_cnt;
    logic             ecoll;
    assign ecoll = wire_coll && !wire_late;

    always_comb begin
        next_tries = tries;   next_jam_pend = jam_pend;
        next_retx = 1'b0;     next_jam = 1'b0;
        next_ok_cnt = ok_cnt; next_maxcol_cnt = maxcol_cnt;
        next_urun_cnt = urun_cnt;
        if (ecoll && tries < RETRY_LIM) begin
            next_retx = 1'b1;
            next_tries = tries + 5'h1;
        end else if (ecoll) begin
            next_maxcol_cnt = maxcol_cnt + 1'b1;
            next_tries = 5'h0;
        end
        if (wire_urun) next_urun_cnt = urun_cnt + 1'b1;
        if (wire_done) begin
            next_ok_cnt = ok_cnt + 1'b1;
            next_tries = 5'h0;
        end
        // jam held back until preamble is out
        if (ecoll || wire_urun) next_jam_pend = 1'b1;
        if (next_jam_pend && wire_pre_done) begin
            next_jam = 1'b1;
            next_jam_pend = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tries <= 5'h0;   jam_pend <= 1'b0;
            retx <= 1'b0;    jam <= 1'b0;
            ok_cnt <= '0;    maxcol_cnt <= '0;
            urun_cnt <= '0;
        end else begin
            tries <= next_tries;   jam_pend <= next_jam_pend;
            retx <= next_retx;     jam <= next_jam;
            ok_cnt <= next_ok_cnt; maxcol_cnt <= next_maxcol_cnt;
            urun_cnt <= next_urun_cnt;
        end
    end

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_clr;
        state == S_SCB_CLR && mem_req |-> mem_we && mem_wdata == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear not zero");
    property p_ext;
        state == S_TCB && acc && ext_mode && wi == W_STD_LAST
            |=> state == S_TCB;
    endproperty
    a_ext: assert property (p_ext) else $error("short ext read");
    property p_op;
        state == S_TCB && acc && wi == W_CMD
            && mem_rdata[OP_LO +: 3] != OP_TX |=> state == S_FIN;
    endproperty
    a_op: assert property (p_op) else $error("bad opcode run");
    property p_nv;
        state == S_DESC && acc && wi[0] && dyn_mode && dptr == 32'h0
            && !(ext_mode && idx < EMB_TBDS) |=> state == S_POLL;
    endproperty
    a_nv: assert property (p_nv) else $error("null ptr used");
    property p_go;
        $rose(tx_go) |-> $past(fetched) >= {5'h0, $past(thr), 3'h0}
            && !($past(state) inside {S_IDLE, S_SCB_CMD, S_SCB_PTR,
                                      S_SCB_CLR, S_TCB, S_FIN})
            || $past(state) == S_STAT;
    endproperty
    a_go: assert property (p_go) else $error("early start");
    property p_eoc;
        push_eoc |-> bcnt != 14'h0 && tbd_arr == NULL_PTR;
    endproperty
    a_eoc: assert property (p_eoc) else $error("stray eoc");
    property p_stat;
        state == S_STAT && acc |-> mem_wdata[C_BIT]
            ##1 state == S_FIN ##1 cmd_done;
    endproperty
    a_stat: assert property (p_stat) else $error("no completion");
    property p_retx;
        ecoll && tries < RETRY_LIM |=> retx && !$stable(tries);
    endproperty
    a_retx: assert property (p_retx) else $error("no retry");
    property p_max;
        ecoll && tries == RETRY_LIM |=> maxcol_cnt == $past(maxcol_cnt) + 1'b1;
    endproperty
    a_max: assert property (p_max) else $error("max coll miss");
    property p_jam;
        jam |-> $past(wire_pre_done);
    endproperty
    a_jam: assert property (p_jam) else $error("jam in preamble");
    c_frame: cover property (state == S_BUF ##[1:200] cmd_done);
    c_poll: cover property (state == S_POLL);
    c_retx: cover property (retx ##[1:50] wire_done);
    c_eoc: cover property (push_eoc);
endmodule
`default_nettype wire

// File: verification/host_mem_model.sv
// Host memory model: 256 words, one access at a time.
// Assumes requests stand until acked; slow adds three wait cycles.
`timescale 1ns/10ps
`default_nettype none
module host_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        slow,
    output logic             ack,
    output logic [31:0]      rdata
);
    logic [31:0] mem [0:255];
    logic [31:0] last;
    logic [1:0]  waited;
    // Idle bus shows inverted stale data, so no late sample can match
    assign rdata = ack ? mem[addr[9:2]] : ~last;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
            waited <= 2'h0;
            last <= 32'h0;
        end else begin
            ack <= req && !ack && (waited == 2'h3 || !slow);
            waited <= (req && !ack) ? waited + 2'h1 : 2'h0;
            if (req && ack && we)
                mem[addr[9:2]] <= wdata;
            if (ack)
                last <= rdata;
        end
    end
endmodule
`default_nettype wire

// File: verification/tx_descriptor_fetch_dma_tb_top.sv
// Bench: transmit engine against the host memory model.
// Assumes command block pointer 100h, descriptor array 200h.
`timescale 1ns/10ps
`default_nettype none
module tx_descriptor_fetch_dma_tb_top;
    import txdma_pkg::*;
    typedef struct {
        logic [4:0] m; logic [2:0] op; logic [31:0] arr, w3; int nw, ne;
    } row_s;
    logic        core_clk, rst_b, cu_start, ext_mode, dyn_mode, slow;
    logic        fifo_ready, wire_pre_done, wire_coll, wire_late;
    logic        wire_urun, wire_done, mem_req, mem_we, mem_ack;
    logic        fifo_valid, fifo_eoc, tx_go, cmd_done, retx, jam;
    logic [31:0] scb_addr, mem_addr, mem_wdata, mem_rdata, fifo_data, first;
    logic [15:0] ok_cnt, maxcol_cnt, urun_cnt;
    int          fails, checks_done, words, eocs, gos, retxs, jams, cyc;
    row_s rows[8] = '{'{5'h00, 3'h4, 32'h200, 32'h02010008, 5, 0},
        '{5'h04, 3'h4, 32'h200, 32'h02010000, 3, 0},
        '{5'h00, 3'h4, 32'h200, 32'h00010008, 2, 0},
        '{5'h04, 3'h4, 32'hFFFFFFFF, 32'h00010004, 2, 1},
        '{5'h05, 3'h4, 32'h200, 32'h03010000, 5, 0},
        '{5'h08, 3'h4, 32'h200, 32'h02010000, 2, 0},
        '{5'h00, 3'h0, 32'h200, 32'h02010008, 0, 0},
        '{5'h12, 3'h4, 32'h200, 32'hFF010000, 3, 0}};
    tx_descriptor_fetch_dma u_dut (.core_clk, .rst_b, .cu_start, .scb_addr,
        .ext_mode, .dyn_mode, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata, .fifo_valid, .fifo_data, .fifo_eoc,
        .fifo_ready, .tx_go, .cmd_done, .wire_pre_done, .wire_coll,
        .wire_late, .wire_urun, .wire_done, .retx, .jam, .ok_cnt,
        .maxcol_cnt, .urun_cnt);
    host_mem_model u_mem (.clk(core_clk), .rst_b, .req(mem_req),
        .we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .slow,
        .ack(mem_ack), .rdata(mem_rdata));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Slow rows stall the sink so the two-word buffer fills
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        fifo_ready <= !slow || cyc[2:0] == 3'h0;
        if (fifo_valid && fifo_ready) begin
            if (words == 0)
                first = fifo_data;
            words++;
            eocs += fifo_eoc;
        end
        gos += tx_go;
        retxs += retx;
        jams += jam;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic pw(input logic [2:0] v);
        @(posedge core_clk);
        {wire_coll, wire_urun, wire_done} <= v;
        @(posedge core_clk);
        {wire_coll, wire_urun, wire_done} <= 3'h0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic run(input row_s r, input logic u);
        int n;
        @(posedge core_clk);
        u_mem.mem[0] = 32'h1;
        u_mem.mem[64] = {13'h0, r.op, 16'h0};
        u_mem.mem[66] = r.arr;
        u_mem.mem[67] = r.w3;
        u_mem.mem[68] = 32'h300;
        u_mem.mem[69] = 32'h8;
        u_mem.mem[70] = 32'h340;
        u_mem.mem[71] = 32'h4;
        u_mem.mem[129] = {15'h0, r.m[3], 16'h8};
        u_mem.mem[130] = r.m[4] ? 32'h0 : 32'h340;
        u_mem.mem[131] = 32'h4;
        {slow, dyn_mode, ext_mode} <= r.m[2:0];
        words = 0;
        eocs = 0;
        gos = 0;
        @(posedge core_clk);
        cu_start <= 1'b1;
        @(posedge core_clk);
        cu_start <= 1'b0;
        if (r.m[4])
            fork
                begin
                    repeat (300) @(negedge core_clk);
                    u_mem.mem[131] = 32'h10004;
                    u_mem.mem[130] = 32'h340;
                end
            join_none
        for (n = 0; n < 3000 && cmd_done !== 1'b1; n++)
            @(negedge core_clk);
        repeat (20) @(negedge core_clk);
        chk(words, r.nw);
        chk(eocs, r.ne);
        chk(gos, r.op == OP_TX);
        chk(u_mem.mem[0], 0);
        chk(u_mem.mem[64], {13'h0, r.op, r.op == OP_TX, 1'b0,
            r.op == OP_TX, u, 12'h0});
        if (r.nw > 0)
            chk(first, r.w3[13:0] != 0 ? 32'h300 : 32'hB0);
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {rst_b, cu_start, ext_mode, dyn_mode, slow} = 5'h00;
        {wire_pre_done, wire_coll, wire_late, wire_urun, wire_done} = 5'h0;
        scb_addr = 32'h0;
        u_mem.mem[1] = 32'h100;
        u_mem.mem[128] = 32'h300;
        u_mem.mem[192] = 32'hB0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk({mem_req, fifo_valid, tx_go, cmd_done, jam, ok_cnt}, 0);
        repeat (16) pw(3'h4);
        chk(retxs, 15);
        chk(maxcol_cnt, 1);
        wire_pre_done <= 1'b1;
        wire_late <= 1'b1;
        pw(3'h4);
        chk(retxs + jams, 16);
        wire_late <= 1'b0;
        wire_pre_done <= 1'b0;
        pw(3'h2);
        chk(jams, 1);
        wire_pre_done <= 1'b1;
        pw(3'h1);
        chk(jams, 2);
        chk({urun_cnt, ok_cnt}, 32'h00010001);
        foreach (rows[i])
            run(rows[i], i == 0);
        wrap_up;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        wrap_up;
    end
endmodule
`default_nettype wire
